// ---- dsc_host.sv ----
`timescale 1ns/1ps
module dsc_host
  import dsc_pkg::*;
#(
  parameter int INIT_CYC = INIT_WAIT_CYC
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  dsc_ctl_if.host          ctl,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest
);
  typedef enum {S_IDLE, S_SEL, S_WR, S_POLL, S_POLLW, S_WAIT, S_DONE} dsc_st_e;
  dsc_st_e     st_q;
  logic [4:0]  step_q;
  logic [3:0]  tog_q;
  logic [31:0] cnt_q;
  logic [15:0] entry_q, img_q, addr, data;
  logic [7:0]  word_q;
  logic        spi_q, go_q, fail_q, busy;

  // -------------------------------------------------------------------
  // avalon slave: always answers in the request cycle
  // -------------------------------------------------------------------
  assign avs_waitrequest = 1'b0;
  assign busy            = (st_q != S_IDLE) && (st_q != S_DONE);
  always_ff @(posedge mclk) begin
    if (rst) begin
      spi_q   <= 1'b0;
      go_q    <= 1'b0;
      entry_q <= DSC_ZERO;
      img_q   <= DSC_ZERO;
    end else begin
      go_q <= 1'b0;
      if (avs_write) begin
        case (avs_address)
          AV_CTRL: begin
            go_q  <= avs_writedata[AV_CTRL_GO];
            spi_q <= avs_writedata[AV_CTRL_SPI];
          end
          AV_ENTRY: entry_q <= avs_writedata[15:0];
          AV_DATA:  img_q   <= avs_writedata[15:0];
          default: ;
        endcase
      end
    end
  end
  always_comb begin
    case (avs_address)
      AV_CTRL:   avs_readdata = {30'd0, spi_q, 1'b0};
      AV_STATUS: avs_readdata = {29'd0, fail_q, (st_q == S_DONE), busy};
      AV_ENTRY:  avs_readdata = {16'd0, entry_q};
      AV_DATA:   avs_readdata = {16'd0, img_q};
      default:   avs_readdata = 32'd0;
    endcase
  end

  // -------------------------------------------------------------------
  // write script
  // -------------------------------------------------------------------
  always_comb begin
    addr = DSC_ZERO;
    data = DSC_ZERO;
    case (step_q)
      5'd0:  begin addr = DSC_SOFTWARE_RESET_CONTROL; data = DSC_ZERO; end
      5'd1:  begin addr = DSC_SOFTWARE_RESET_CONTROL; data = DSC_ONE; end
      5'd2:  begin addr = DSC_PLL_FEEDBACK_DIVIDER; data = DSC_FEEDBACK_RESET; end
      5'd3:  begin addr = DSC_PLL_INPUT_PRESCALE; data = DSC_PRESCALE_DIV4; end
      5'd4:  begin addr = DSC_CORE_CLOCK_SOURCE_SEL; data = DSC_SRC_PLL; end
      5'd5:  begin addr = DSC_CLOCK_OUTPUT_CONTROL; data = DSC_DIGITAL_CLOCK_OUTPUT_PIN_EXAMPLE; end
      5'd6:  begin addr = DSC_PLL_TURN_ON; data = DSC_ONE; end
      5'd7:  begin addr = DSC_SUBSYSTEM_POWER_FIRST; data = DSC_POWER_FIRST_ALL; end
      5'd8:  begin addr = DSC_SUBSYSTEM_POWER_SECOND; data = DSC_POWER_SECOND_OFF; end
      5'd9:  begin addr = DSC_CORE_SLEEP_CONTROL; data = DSC_ONE; end
      5'd10: begin addr = DSC_PROGRAM_MEM_BASE + 16'(word_q); data = img_q; end
      5'd11: begin addr = DSC_DATA_MEM_FIRST_BASE + 16'(word_q); data = img_q; end
      5'd12: begin addr = DSC_DATA_MEM_SECOND_BASE + 16'(word_q); data = img_q; end
      5'd13: begin addr = DSC_PROGRAM_ENTRY_POINT; data = entry_q; end
      5'd14: begin addr = DSC_CORE_TRIGGER_SOURCE; data = DSC_TRIGGER_INTERNAL; end
      5'd15: begin addr = DSC_CORE_SLEEP_CONTROL; data = DSC_ZERO; end
      5'd16: begin addr = DSC_CORE_RUN_CONTROL; data = DSC_ZERO; end
      5'd17: begin addr = DSC_CORE_RUN_CONTROL; data = DSC_ONE; end
      default: ;
    endcase
  end

  // -------------------------------------------------------------------
  // sequencer
  // -------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q        <= S_IDLE;
      step_q      <= 5'd0;
      tog_q       <= 4'd0;
      cnt_q       <= 32'd0;
      word_q      <= 8'd0;
      fail_q      <= 1'b0;
      ctl.wr_valid <= 1'b0;
      ctl.wr_addr <= DSC_ZERO;
      ctl.wr_data <= DSC_ZERO;
      ctl.rd_valid <= 1'b0;
      ctl.sel_o   <= 1'b1;
      ctl.sel_oe  <= 1'b0;
    end else begin
      ctl.wr_valid <= 1'b0;
      ctl.rd_valid <= 1'b0;
      // every refused write is seen, including the last one of the script
      if (ctl.wr_fail)
        fail_q <= 1'b1;
      case (st_q)
        S_IDLE: if (go_q) begin
          step_q <= 5'd0;
          word_q <= 8'd0;
          fail_q <= 1'b0;
          tog_q  <= 4'd0;
          ctl.sel_oe <= spi_q;
          st_q   <= spi_q ? S_SEL : S_WR;
        end
        S_SEL: begin
          ctl.sel_o <= !ctl.sel_o;
          tog_q     <= tog_q + 4'd1;
          if (tog_q == 4'(2 * DSC_SELECT_TOGGLES - 1))
            st_q <= S_WR;
        end
        S_WR: begin
          ctl.wr_valid <= 1'b1;
          ctl.wr_addr  <= addr;
          ctl.wr_data  <= data;
          if (step_q >= 5'd10 && step_q <= 5'd12 &&
              word_q != 8'(DSC_MEM_WORDS - 1)) begin
            word_q <= word_q + 8'd1;
          end else begin
            word_q <= 8'd0;
            step_q <= step_q + 5'd1;
            if (step_q == 5'd6) begin
              cnt_q <= 32'd0;
              st_q  <= S_POLL;
            end else if (step_q == 5'd17) begin
              cnt_q <= 32'd0;
              st_q  <= S_WAIT;
            end
          end
        end
        S_POLL: begin
          cnt_q        <= cnt_q + 32'd1;
          ctl.wr_addr  <= DSC_PLL_LOCK_STATUS;
          ctl.rd_valid <= 1'b1;
          st_q         <= S_POLLW;
        end
        S_POLLW: begin
          cnt_q <= cnt_q + 32'd1;
          // read data stands only one cycle after the request
          if (ctl.rd_valid) begin
            st_q <= S_POLLW;
          end else if (ctl.rd_data[DSC_LOCK_BIT]) begin
            st_q <= S_WR;
          end else if (cnt_q > 32'(LOCK_MAX_CYC)) begin
            fail_q <= 1'b1;
            st_q   <= S_DONE;
          end else begin
            st_q <= S_POLL;
          end
        end
        S_WAIT: begin
          cnt_q <= cnt_q + 32'd1;
          if (cnt_q == 32'(INIT_CYC - 1))
            st_q <= S_DONE;
        end
        S_DONE: if (go_q)
          st_q <= S_IDLE;
        default: st_q <= S_IDLE;
      endcase
    end
  end
endmodule // dsc_host

// ---- dsc_pkg.sv ----
// Functional notes
// - host halts core before bulk memory loads
// - small live changes may use safeload
// - host toggles select line three times first
// - feedback divider 16-bit, defaults to 96
// - prescale code 2 divides clock by four
// - source select 1 picks pll clock
// - clock output code 5 enables output pin
// - host waits for lock before continuing
// - power word 0x4fff powers all but gen3
// - second power word zero keeps blocks off
// - program memory loaded as one block
// - first data memory loaded from zero
// - second data memory loaded from 0x6000
// - core starts at entry point register
// - trigger source 2 selects internal pulse
// - host sets remaining nondefault registers first
// - host waits 50 us after start
// - clock output pin set only by its register
// - lock shows in status bit 0
// - writes fail while pll is locking
package dsc_pkg;
  // -------------------------------------------------------------------
  // device register offsets
  // -------------------------------------------------------------------
  localparam logic [15:0] DSC_PLL_FEEDBACK_DIVIDER   = 16'hf000;
  localparam logic [15:0] DSC_PLL_INPUT_PRESCALE     = 16'hf001;
  localparam logic [15:0] DSC_CORE_CLOCK_SOURCE_SEL  = 16'hf002;
  localparam logic [15:0] DSC_PLL_TURN_ON            = 16'hf003;
  localparam logic [15:0] DSC_PLL_LOCK_STATUS        = 16'hf004;
  localparam logic [15:0] DSC_CLOCK_OUTPUT_CONTROL   = 16'hf005;
  localparam logic [15:0] DSC_SUBSYSTEM_POWER_FIRST  = 16'hf050;
  localparam logic [15:0] DSC_SUBSYSTEM_POWER_SECOND = 16'hf051;
  localparam logic [15:0] DSC_CORE_SLEEP_CONTROL     = 16'hf400;
  localparam logic [15:0] DSC_CORE_TRIGGER_SOURCE    = 16'hf401;
  localparam logic [15:0] DSC_CORE_RUN_CONTROL       = 16'hf402;
  localparam logic [15:0] DSC_PROGRAM_ENTRY_POINT    = 16'hf404;
  localparam logic [15:0] DSC_SOFTWARE_RESET_CONTROL = 16'hf890;
  localparam logic [15:0] DSC_PROGRAM_MEM_BASE       = 16'hc000;
  localparam logic [15:0] DSC_DATA_MEM_FIRST_BASE    = 16'h0000;
  localparam logic [15:0] DSC_DATA_MEM_SECOND_BASE   = 16'h6000;
  localparam int          DSC_MEM_WORDS              = 16;
  // -------------------------------------------------------------------
  // reset and example values
  // -------------------------------------------------------------------
  localparam logic [15:0] DSC_FEEDBACK_RESET  = 16'h0060;
  localparam logic [15:0] DSC_PRESCALE_DIV4   = 16'h0002;
  localparam logic [15:0] DSC_SRC_PLL         = 16'h0001;
  localparam logic [15:0] DSC_DIGITAL_CLOCK_OUTPUT_PIN_EXAMPLE  = 16'h0005;
  localparam logic [15:0] DSC_POWER_FIRST_ALL = 16'h4fff;
  localparam logic [15:0] DSC_POWER_SECOND_OFF = 16'h0000;
  localparam logic [15:0] DSC_TRIGGER_INTERNAL = 16'h0002;
  localparam logic [15:0] DSC_ONE             = 16'h0001;
  localparam logic [15:0] DSC_ZERO            = 16'h0000;
  localparam int          DSC_LOCK_BIT        = 0;
  localparam int          DSC_POWER_GEN3_BIT  = 15;
  localparam int          DSC_SELECT_TOGGLES  = 3;
  // -------------------------------------------------------------------
  // timing
  // -------------------------------------------------------------------
  localparam int CLK_MHZ         = 100;
  localparam int LOCK_MAX_NS     = 10666000;
  localparam int LOCK_MAX_CYC    = LOCK_MAX_NS * CLK_MHZ / 1000;
  localparam int INIT_WAIT_US    = 50;
  localparam int INIT_WAIT_CYC   = INIT_WAIT_US * CLK_MHZ;
  localparam int LOCK_SIM_CYC    = 64;
  // -------------------------------------------------------------------
  // avalon slave offsets (byte addresses)
  // -------------------------------------------------------------------
  localparam logic [3:0] AV_CTRL      = 4'h0;
  localparam logic [3:0] AV_STATUS    = 4'h4;
  localparam logic [3:0] AV_ENTRY     = 4'h8;
  localparam logic [3:0] AV_DATA      = 4'hc;
  localparam int         AV_CTRL_GO   = 0;
  localparam int         AV_CTRL_SPI  = 1;
endpackage

// ---- dsc_ctl_if.sv ----
`timescale 1ns/1ps
interface dsc_ctl_if;
  logic        wr_valid;
  logic [15:0] wr_addr;
  logic [15:0] wr_data;
  logic        wr_accept;
  logic        wr_fail;
  logic        rd_valid;
  logic [15:0] rd_data;
  logic        sel_o;
  logic        sel_oe;
  modport dev (input wr_valid, wr_addr, wr_data, rd_valid, sel_o, sel_oe,
               output wr_accept, wr_fail, rd_data);
  modport host (output wr_valid, wr_addr, wr_data, rd_valid, sel_o, sel_oe,
                input wr_accept, wr_fail, rd_data);
endinterface

// ---- dsc_dev.sv ----
`timescale 1ns/1ps
module dsc_dev
  import dsc_pkg::*;
#(
  parameter int LOCK_CYC = LOCK_SIM_CYC
) (
  input  wire logic  mclk,
  input  wire logic  rst,
  dsc_ctl_if.dev     ctl,
  output logic       spi_mode,
  output logic       soft_reset_active,
  output logic [3:0] pll_prescale_div,
  output logic       core_clk_from_pll,
  output logic       digital_clock_output_pin,
  output logic [15:0] power_first,
  output logic [15:0] power_second,
  output logic       core_running,
  output logic       core_trigger_internal,
  output logic [15:0] core_pc,
  output logic       pll_locked
);
  logic [15:0] fb_q, pre_q, src_q, on_q, clko_q, pw1_q, pw2_q;
  logic [15:0] sleep_q, trig_q, run_q, entry_q, srst_q, rd_q;
  logic [31:0] lock_cnt_q;
  logic        locking_q, lock_q;
  logic        sel_s1_q, sel_s2_q, sel_s3_q;
  logic [1:0]  rises_q;
  logic [2:0]  div_q;
  logic        wr_ok;

  // -------------------------------------------------------------------
  // select-pin toggle counter
  // -------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      sel_s1_q <= 1'b1;
      sel_s2_q <= 1'b1;
      sel_s3_q <= 1'b1;
    end else begin
      // released pin idles high on its pull-up, so enabling the driver is no edge
      sel_s1_q <= !ctl.sel_oe | ctl.sel_o;
      sel_s2_q <= sel_s1_q;
      sel_s3_q <= sel_s2_q;
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      rises_q  <= 2'd0;
      spi_mode <= 1'b0;
    end else if (sel_s2_q && !sel_s3_q && !spi_mode) begin
      rises_q <= rises_q + 2'd1;
      if (rises_q == 2'(DSC_SELECT_TOGGLES - 1))
        spi_mode <= 1'b1;
    end
  end

  // -------------------------------------------------------------------
  // register writes; refused while pll locking
  // -------------------------------------------------------------------
  assign wr_ok         = ctl.wr_valid && !locking_q;
  assign ctl.wr_accept = wr_ok;
  assign ctl.wr_fail   = ctl.wr_valid && locking_q;

  always_ff @(posedge mclk) begin
    if (rst) begin
      fb_q    <= DSC_FEEDBACK_RESET;
      pre_q   <= DSC_ZERO;
      src_q   <= DSC_ZERO;
      on_q    <= DSC_ZERO;
      clko_q  <= DSC_ZERO;
      pw1_q   <= DSC_ZERO;
      pw2_q   <= DSC_ZERO;
      sleep_q <= DSC_ZERO;
      trig_q  <= DSC_ZERO;
      run_q   <= DSC_ZERO;
      entry_q <= DSC_ZERO;
      srst_q  <= DSC_ONE;
    end else if (wr_ok) begin
      case (ctl.wr_addr)
        DSC_PLL_FEEDBACK_DIVIDER:   fb_q    <= ctl.wr_data;
        DSC_PLL_INPUT_PRESCALE:     pre_q   <= ctl.wr_data;
        DSC_CORE_CLOCK_SOURCE_SEL:  src_q   <= ctl.wr_data;
        DSC_PLL_TURN_ON:            on_q    <= ctl.wr_data;
        DSC_CLOCK_OUTPUT_CONTROL:   clko_q  <= ctl.wr_data;
        DSC_SUBSYSTEM_POWER_FIRST:  pw1_q   <= ctl.wr_data;
        DSC_SUBSYSTEM_POWER_SECOND: pw2_q   <= ctl.wr_data;
        DSC_CORE_SLEEP_CONTROL:     sleep_q <= ctl.wr_data;
        DSC_CORE_TRIGGER_SOURCE:    trig_q  <= ctl.wr_data;
        DSC_CORE_RUN_CONTROL:       run_q   <= ctl.wr_data;
        DSC_PROGRAM_ENTRY_POINT:    entry_q <= ctl.wr_data;
        DSC_SOFTWARE_RESET_CONTROL: srst_q  <= ctl.wr_data;
        default: ;
      endcase
    end
  end

  // -------------------------------------------------------------------
  // pll lock model: fixed count after turn-on write
  // -------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      locking_q  <= 1'b0;
      lock_q     <= 1'b0;
      lock_cnt_q <= 32'd0;
    end else if (wr_ok && ctl.wr_addr == DSC_PLL_TURN_ON) begin
      locking_q  <= ctl.wr_data[0];
      lock_q     <= 1'b0;
      lock_cnt_q <= 32'd0;
    end else if (locking_q) begin
      lock_cnt_q <= lock_cnt_q + 32'd1;
      if (lock_cnt_q == 32'(LOCK_CYC - 1)) begin
        locking_q <= 1'b0;
        lock_q    <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst)
      rd_q <= DSC_ZERO;
    else if (ctl.rd_valid)
      rd_q <= (ctl.wr_addr == DSC_PLL_LOCK_STATUS) ? {15'd0, lock_q} : DSC_ZERO;
  end
  assign ctl.rd_data = rd_q;

  // -------------------------------------------------------------------
  // clock output pin: divider enabled only by its register
  // -------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      div_q                    <= 3'd0;
      digital_clock_output_pin <= 1'b0;
    end else if (clko_q == DSC_DIGITAL_CLOCK_OUTPUT_PIN_EXAMPLE) begin
      div_q <= div_q + 3'd1;
      if (div_q == 3'd3) begin
        div_q                    <= 3'd0;
        digital_clock_output_pin <= !digital_clock_output_pin;
      end
    end else begin
      div_q                    <= 3'd0;
      digital_clock_output_pin <= 1'b0;
    end
  end

  // -------------------------------------------------------------------
  // core control
  // -------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst)
      core_pc <= DSC_ZERO;
    else if (!core_running)
      core_pc <= entry_q;
    else
      core_pc <= core_pc + 16'd1;
  end

  always_comb begin
    case (pre_q[1:0])
      2'd0:    pll_prescale_div = 4'd1;
      2'd1:    pll_prescale_div = 4'd2;
      2'd2:    pll_prescale_div = 4'd4;
      default: pll_prescale_div = 4'd8;
    endcase
  end

  assign soft_reset_active     = (srst_q == DSC_ZERO);
  assign core_clk_from_pll     = (src_q == DSC_SRC_PLL);
  assign power_first           = pw1_q;
  assign power_second          = pw2_q;
  assign core_running          = run_q[0] && (sleep_q == DSC_ZERO) && !soft_reset_active;
  assign core_trigger_internal = (trig_q == DSC_TRIGGER_INTERNAL);
  assign pll_locked            = lock_q;
endmodule // dsc_dev

// ---- dsc_link_asserts.sv ----
`timescale 1ns/1ps
module dsc_link_asserts
  import dsc_pkg::*;
#(
  parameter int LOCK_CYC = 16
) (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        wr_valid,
  input wire logic [15:0] wr_addr,
  input wire logic [15:0] wr_data,
  input wire logic        wr_accept,
  input wire logic        wr_fail,
  input wire logic        rd_valid,
  input wire logic [15:0] rd_data,
  input wire logic        sel_o,
  input wire logic        sel_oe
);
  localparam int LOCK_BOUND = LOCK_CYC + 40;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  // ------------------------------
  // helper state
  // ------------------------------
  logic       on_q;
  logic       any_q;
  logic       sleep_q;
  logic       stop_q;
  logic [3:0] rises_q;
  int         since_q;
  always_ff @(posedge mclk) begin
    if (rst) begin
      on_q    <= 1'b0;
      since_q <= 0;
    end else if (wr_accept && wr_addr == DSC_PLL_TURN_ON && wr_data[0]) begin
      on_q    <= 1'b1;
      since_q <= 0;
    end else if (since_q < 1000) begin
      since_q <= since_q + 1;
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      any_q <= 1'b0;
    end else if (wr_valid) begin
      any_q <= 1'b1;
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      sleep_q <= 1'b0;
      stop_q  <= 1'b0;
    end else if (wr_accept && wr_addr == DSC_CORE_SLEEP_CONTROL) begin
      sleep_q <= wr_data[0];
    end else if (wr_accept && wr_addr == DSC_CORE_RUN_CONTROL) begin
      stop_q  <= !wr_data[0];
    end
  end
  // rises only count while the host actually drives the select pin
  always_ff @(posedge mclk) begin
    if (rst) begin
      rises_q <= 4'h0;
    end else if (sel_oe && $rose(sel_o) && rises_q != 4'hf) begin
      rises_q <= rises_q + 4'h1;
    end
  end
  // ------------------------------
  // link properties
  // ------------------------------
  sequence s_turn_on;
    wr_accept && wr_addr == DSC_PLL_TURN_ON && wr_data[0];
  endsequence
  sequence s_lock_read;
    rd_valid && wr_addr == DSC_PLL_LOCK_STATUS;
  endsequence
  a_answer_once:
  assert property (wr_valid |-> (wr_accept ^ wr_fail)) else $error("write not answered once");
  a_idle_silent:
  assert property (!wr_valid |-> !wr_accept && !wr_fail) else $error("answer without write");
  a_locking_refuses:
  assert property (s_turn_on |=> (!wr_accept) [*8]) else $error("write taken while locking");
  a_host_waits:
  assert property (wr_valid |-> !(on_q && since_q < LOCK_CYC - 1))
    else $error("host wrote before lock");
  a_lock_low:
  assert property (rd_valid && wr_addr == DSC_PLL_LOCK_STATUS && on_q && since_q < LOCK_CYC - 1
    |=> !rd_data[DSC_LOCK_BIT]) else $error("lock shown too early");
  a_lock_reported:
  assert property (s_turn_on |-> ##[1:LOCK_BOUND] s_lock_read ##1 rd_data[DSC_LOCK_BIT])
    else $error("lock never reported");
  a_first_reset:
  assert property (wr_valid && !any_q |-> wr_addr == DSC_SOFTWARE_RESET_CONTROL
    && wr_data == DSC_ZERO) else $error("first write not reset entry");
  a_feedback_value:
  assert property (wr_valid && wr_addr == DSC_PLL_FEEDBACK_DIVIDER |-> wr_data == 16'h0060)
    else $error("feedback divider value wrong");
  a_mem_asleep:
  assert property (wr_valid && wr_addr < 16'hf000 |-> sleep_q) else $error("memory load awake");
  a_run_after_stop:
  assert property (wr_valid && wr_addr == DSC_CORE_RUN_CONTROL && wr_data[0] |-> stop_q)
    else $error("start without stop");
  a_spi_toggles:
  assert property (wr_valid && rises_q != 4'h0 |-> rises_q >= 4'h3)
    else $error("too few select toggles");
endmodule // dsc_link_asserts

// ---- tb.sv ----
`timescale 1ns/1ps
module tb;
  import dsc_pkg::*;
  typedef struct {
    logic [15:0] a;
    logic [15:0] d;
    int          s;
    logic [15:0] e;
  } dsc_row_s;
  localparam int LK = 16;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        spi_mode, soft_reset_active, core_clk_from_pll, core_running;
  logic        core_trigger_internal, pll_locked, b_spi, b_srst, b_src, b_dco, b_run;
  logic        b_trig, b_lock;
  logic [3:0]  pll_prescale_div, b_div;
  logic [15:0] power_first, power_second, core_pc, b_pw1, b_pw2, b_pc, v;
  int          failures = 0;
  int          num_checks = 0;
  int          n;
  dsc_row_s    rows[19];
  dsc_ctl_if ctl ();
  dsc_ctl_if ctl2 ();
  always #5 mclk = ~mclk;
  dsc_dev #(.LOCK_CYC(LK)) u_dsc_dev (.mclk, .rst, .ctl(ctl.dev), .spi_mode,
    .soft_reset_active, .pll_prescale_div, .core_clk_from_pll, .digital_clock_output_pin(),
    .power_first, .power_second, .core_running, .core_trigger_internal, .core_pc, .pll_locked);
  dsc_host #(.INIT_CYC(20)) u_dsc_host (.mclk, .rst, .ctl(ctl.host), .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest);
  // second device end, driven directly so that broken host behaviour can be forced
  dsc_dev #(.LOCK_CYC(LK)) u_dsc_dev_b (.mclk, .rst, .ctl(ctl2.dev), .spi_mode(b_spi),
    .soft_reset_active(b_srst), .pll_prescale_div(b_div), .core_clk_from_pll(b_src),
    .digital_clock_output_pin(b_dco), .power_first(b_pw1), .power_second(b_pw2),
    .core_running(b_run), .core_trigger_internal(b_trig), .core_pc(b_pc), .pll_locked(b_lock));
  dsc_link_asserts #(.LOCK_CYC(LK)) u_dsc_link_asserts (.mclk, .rst,
    .wr_valid(ctl.wr_valid), .wr_addr(ctl.wr_addr), .wr_data(ctl.wr_data),
    .wr_accept(ctl.wr_accept), .wr_fail(ctl.wr_fail), .rd_valid(ctl.rd_valid),
    .rd_data(ctl.rd_data), .sel_o(ctl.sel_o), .sel_oe(ctl.sel_oe));
  // ------------------------------
  // shared tasks
  // ------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    if (failures == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge mclk);
    end while (avs_waitrequest !== 1'b0);
    v = avs_readdata[15:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic lw(input logic [15:0] a, input logic [15:0] d, input logic f);
    @(posedge mclk);
    ctl2.wr_valid <= 1'b1;
    ctl2.wr_addr <= a;
    ctl2.wr_data <= d;
    @(negedge mclk);
    chk({15'h0, ctl2.wr_fail}, {15'h0, f});
    @(posedge mclk);
    ctl2.wr_valid <= 1'b0;
    @(negedge mclk);
  endtask
  task automatic lr(input logic [15:0] a);
    @(posedge mclk);
    ctl2.rd_valid <= 1'b1;
    ctl2.wr_addr <= a;
    @(posedge mclk);
    ctl2.rd_valid <= 1'b0;
    @(negedge mclk);
    v = ctl2.rd_data;
  endtask
  function automatic logic [15:0] pick(input int s);
    case (s)
      0: return {12'h0, b_div};
      1: return {15'h0, b_src};
      2: return b_pw1;
      3: return b_pw2;
      4: return {15'h0, b_trig};
      5: return b_pc;
      6: return {15'h0, b_run};
      default: return {15'h0, b_srst};
    endcase
  endfunction
  // ------------------------------
  // tests
  // ------------------------------
  initial begin
    ctl2.wr_valid = 1'b0;
    ctl2.rd_valid = 1'b0;
    ctl2.wr_addr = 16'h0;
    ctl2.wr_data = 16'h0;
    ctl2.sel_o = 1'b1;
    ctl2.sel_oe = 1'b0;
    rows = '{'{16'hf001, 16'h0, 0, 16'h1}, '{16'hf001, 16'h1, 0, 16'h2},
      '{16'hf001, 16'h2, 0, 16'h4}, '{16'hf001, 16'h3, 0, 16'h8},
      '{16'hf002, 16'h1, 1, 16'h1}, '{16'hf002, 16'h0, 1, 16'h0},
      '{16'hf050, 16'h4fff, 2, 16'h4fff}, '{16'hf051, 16'h0, 3, 16'h0},
      '{16'hf401, 16'h2, 4, 16'h1}, '{16'hf401, 16'h0, 4, 16'h0},
      '{16'hf890, 16'h0, 7, 16'h1}, '{16'hf890, 16'h1, 7, 16'h0},
      '{16'hf400, 16'h0, 6, 16'h0}, '{16'hf402, 16'h0, 6, 16'h0},
      '{16'hf404, 16'h0123, 5, 16'h0123}, '{16'hf402, 16'h1, 6, 16'h1},
      '{16'hf400, 16'h1, 6, 16'h0}, '{16'hf400, 16'h0, 6, 16'h1},
      '{16'hf402, 16'h0, 6, 16'h0}};
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    chk({12'h0, b_lock, b_run, b_srst, b_spi}, 16'h0);
    chk({15'h0, avs_waitrequest}, 16'h0);
    foreach (rows[i]) begin
      lw(rows[i].a, rows[i].d, 1'b0);
      @(negedge mclk);
      chk(pick(rows[i].s), rows[i].e);
    end
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk);
      ctl2.sel_oe <= 1'b1;
      ctl2.sel_o <= 1'b0;
      repeat (2) @(posedge mclk);
      ctl2.sel_o <= 1'b1;
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      chk({15'h0, b_spi}, {15'h0, i == 2});
    end
    lw(DSC_PLL_TURN_ON, DSC_ONE, 1'b0);
    lw(DSC_CLOCK_OUTPUT_CONTROL, DSC_DIGITAL_CLOCK_OUTPUT_PIN_EXAMPLE, 1'b1);
    lr(DSC_PLL_LOCK_STATUS);
    chk({15'h0, v[0]}, 16'h0);
    n = 0;
    repeat (LK + 4) begin
      @(negedge mclk);
      if (b_dco !== 1'b0) n++;
    end
    chk(n[15:0], 16'h0);
    chk({15'h0, b_lock}, 16'h1);
    lr(DSC_PLL_LOCK_STATUS);
    chk({15'h0, v[0]}, 16'h1);
    lw(DSC_CLOCK_OUTPUT_CONTROL, DSC_DIGITAL_CLOCK_OUTPUT_PIN_EXAMPLE, 1'b0);
    n = 0;
    repeat (16) begin
      @(negedge mclk);
      if (b_dco === 1'b1) n++;
    end
    chk(n[15:0], 16'h8);
    // host path: the unmapped write must leave nothing behind
    av(1'b1, AV_ENTRY, 32'h0000_0040);
    av(1'b1, AV_DATA, 32'h0000_a5a5);
    av(1'b1, 4'h2, 32'hffff_ffff);
    av(1'b0, 4'h2, 32'h0);
    chk(v, 16'h0);
    av(1'b0, AV_ENTRY, 32'h0);
    chk(v, 16'h0040);
    av(1'b1, AV_CTRL, 32'h0000_0003);
    n = 0;
    do begin
      av(1'b0, AV_STATUS, 32'h0);
      n++;
    end while (v[1] !== 1'b1 && n < 500);
    chk({13'h0, v[2:0]}, 16'h2);
    chk({10'h0, core_clk_from_pll, core_trigger_internal, core_running, spi_mode, pll_locked,
      soft_reset_active}, 16'h003e);
    chk({12'h0, pll_prescale_div}, 16'h4);
    chk(power_first, DSC_POWER_FIRST_ALL);
    chk(power_second, DSC_POWER_SECOND_OFF);
    chk({15'h0, core_pc > 16'h0040}, 16'h1);
    conclude();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    conclude();
  end
endmodule // tb
